/* src/adc_conv_ctrl.sv */
/*
  Converter conversion control: power, start source selection,
  tracking sequence, SAR timing, result formatting and APB registers.
  Assumes timer overflow inputs are one-cycle pulses on clk_i and the
  strobe pin and comparator are asynchronous.
*/
`timescale 1ns/1ps

// Overview of operation
// - Converter runs only while power enable set
// - Ground negative input means single-ended
// - Single-ended result is unsigned ten bits
// - Differential right-aligned result is sign-extended
// - Differential left-aligned low bits read zero
// - Load result bytes at conversion end, aligned
// - Single-ended unused result bits read zero
// - SAR clock divided from system clock
// - Trigger select picks one of six sources
// - Software writes active bit to start
// - Active bit high for whole conversion
// - Active fall at conversion end sets done flag, interrupt
// - Timer 2/3 overflow byte follows mode
// - Default mode tracks except while converting
// - Low-power mode tracks three SAR clocks first
// - Strobe low-power mode tracks while strobe low
// - Tracking shut down in standby or sleep
// - Divider field equals ratio minus one
module adc_conv_ctrl (
  input  wire logic        clk_i,          // System clock, 250 MHz
  input  wire logic        nrst_i,         // Sync reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB write
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic [31:0]      prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        tmr0_ovf_i,     // Timer 0 overflow pulse
  input  wire logic        tmr1_ovf_i,     // Timer 1 overflow pulse
  input  wire logic        tmr2_lo_ovf_i,  // Timer 2 low byte overflow
  input  wire logic        tmr2_hi_ovf_i,  // Timer 2 high byte overflow
  input  wire logic        tmr2_split_i,   // Timer 2 in 8-bit mode
  input  wire logic        tmr3_lo_ovf_i,  // Timer 3 low byte overflow
  input  wire logic        tmr3_hi_ovf_i,  // Timer 3 high byte overflow
  input  wire logic        tmr3_split_i,   // Timer 3 in 8-bit mode
  input  wire logic        external_convert_strobe_i, // Strobe pin
  input  wire logic        cmp_i,          // Comparator, asynchronous
  output logic [9:0]       dac_code_o,     // Trial code to the DAC
  output logic             track_o,        // Track-and-hold tracking
  output logic             analog_on_o,    // Analog powered
  output logic             done_irq_o      // Done interrupt request
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic       converter_power_enable_ff;     // Power enable
  logic       low_power_track_select_ff;     // Low-power tracking
  logic       conversion_done_flag_ff;       // Done flag
  logic       conversion_active_ff;          // Active bit
  logic [2:0] conversion_trigger_select_ff;  // Start source
  logic [4:0] sar_clock_divider_ff;          // Divider field
  logic       left_align_select_ff;          // Alignment
  logic [4:0] neg_input_ff;                  // Negative input selection
  logic       standby_ff;                    // Chip standby
  logic [7:0] result_high_byte_ff;           // Result high byte
  logic [7:0] result_low_byte_ff;            // Result low byte

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,  // Waiting for a start
    ST_TRACK   = 2'b01,  // Low-power tracking period
    ST_CONVERT = 2'b10,  // Resolving bits
    ST_ARMED   = 2'b11   // Strobe low, tracking in low-power mode
  } seq_state_t;

  seq_state_t state_ff;    // Current state
  seq_state_t nxt_state;   // Next state
  logic [3:0] clk_cnt_ff;  // SAR clock counter
  logic [3:0] nxt_clk_cnt; // Next counter value

  // Synchronisers
  logic strobe_meta_ff;  // Strobe first stage
  logic strobe_sync_ff;  // Strobe second stage
  logic strobe_prev_ff;  // Strobe delayed, edge detect
  logic cmp_meta_ff;     // Comparator first stage
  logic cmp_sync_ff;     // Comparator second stage

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic       wr_acc;      // Write access phase
  logic       rd_acc;      // Read access phase
  logic       hit_ctrl;    // Control register selected
  logic       hit_cfg;     // Config register selected
  logic       hit_res;     // Result register selected
  logic       hit_in;      // Input register selected
  logic       mapped;      // Any register selected
  logic       strobe_rise; // Synchronised rising edge
  logic       tmr2_ovf;    // Timer 2 overflow by mode
  logic       tmr3_ovf;    // Timer 3 overflow by mode
  logic       hw_start;    // Hardware start event
  logic       sw_start;    // Software start write
  logic       start;       // Any accepted start
  logic       sar_tick;    // SAR clock enable
  logic       conv_end;    // Last SAR clock of conversion
  logic       differential;// Differential mode
  logic [9:0] code;        // Raw result code
  logic [9:0] sar_trial;   // SAR trial register
  logic [9:0] sar_mask;    // SAR bit under test
  logic [15:0] formatted;  // Result word as loaded
  logic [31:0] rd_mux;     // Read data select

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  assign wr_acc   = psel && penable && pwrite && pready;  // Completing edge
  assign rd_acc   = psel && penable && !pwrite;
  assign hit_ctrl = hit(paddr, adc_ctrl_pkg::CONTROL_OFFS);
  assign hit_cfg  = hit(paddr, adc_ctrl_pkg::CONFIG_OFFS);
  assign hit_res  = hit(paddr, adc_ctrl_pkg::RESULT_OFFS);
  assign hit_in   = hit(paddr, adc_ctrl_pkg::INPUT_OFFS);
  assign mapped   = hit_ctrl || hit_cfg || hit_res || hit_in;

  // Timer 2/3 source follows the timer mode
  assign tmr2_ovf = tmr2_split_i ? tmr2_lo_ovf_i : tmr2_hi_ovf_i;
  assign tmr3_ovf = tmr3_split_i ? tmr3_lo_ovf_i : tmr3_hi_ovf_i;
  assign strobe_rise = strobe_sync_ff && !strobe_prev_ff;

  // Source selection
  always_comb begin
    unique case (adc_ctrl_pkg::trig_sel_t'(conversion_trigger_select_ff))
      adc_ctrl_pkg::TRIG_TMR0:   hw_start = tmr0_ovf_i;
      adc_ctrl_pkg::TRIG_TMR2:   hw_start = tmr2_ovf;
      adc_ctrl_pkg::TRIG_TMR1:   hw_start = tmr1_ovf_i;
      adc_ctrl_pkg::TRIG_STROBE: hw_start = strobe_rise;
      adc_ctrl_pkg::TRIG_TMR3:   hw_start = tmr3_ovf;
      default:                   hw_start = 1'b0;         // Soft, unused
    endcase
  end

  assign sw_start = wr_acc && hit_ctrl
                    && pwdata[adc_ctrl_pkg::ACTIVE_BIT]
                    && (conversion_trigger_select_ff == 3'b000);
  // Starts ignored while busy or powered down: one pulse, one conversion
  assign start = converter_power_enable_ff && !conversion_active_ff
                 && (sw_start || hw_start);
  assign conv_end = (state_ff == ST_CONVERT) && sar_tick
                    && (clk_cnt_ff == 4'(adc_ctrl_pkg::CONVERT_CLKS - 4'h1));
  assign differential = (neg_input_ff != adc_ctrl_pkg::NEG_GND);
  assign code = sar_trial;

  // Result formatting
  always_comb begin
    if (left_align_select_ff) begin
      formatted = {code, 6'h00};
    end else if (differential) begin
      formatted = {{6{code[9]}}, code};
    end else begin
      formatted = {6'h00, code};
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_clk_cnt = clk_cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start && low_power_track_select_ff) begin
          nxt_state   = ST_TRACK;
          nxt_clk_cnt = 4'h0;
        end else if (start) begin
          nxt_state   = ST_CONVERT;
          nxt_clk_cnt = 4'h0;
        end else if (low_power_track_select_ff && converter_power_enable_ff
                     && conversion_trigger_select_ff == 3'b100
                     && !strobe_sync_ff) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (strobe_rise) begin
          nxt_state   = ST_CONVERT;
          nxt_clk_cnt = 4'h0;
        end else if (!low_power_track_select_ff
                     || conversion_trigger_select_ff != 3'b100) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          if (clk_cnt_ff == 4'(adc_ctrl_pkg::TRACK_CLKS - 4'h1)) begin
            nxt_state   = ST_CONVERT;
            nxt_clk_cnt = 4'h0;
          end else begin
            nxt_clk_cnt = 4'(clk_cnt_ff + 4'h1);
          end
        end
      end
      ST_CONVERT: begin
        if (conv_end) begin
          nxt_state = ST_IDLE;
        end else if (sar_tick) begin
          nxt_clk_cnt = 4'(clk_cnt_ff + 4'h1);
        end
      end
    endcase
    if (!converter_power_enable_ff) begin
      nxt_state   = ST_IDLE;
      nxt_clk_cnt = 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  sar_clk_div u_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (converter_power_enable_ff && state_ff != ST_IDLE
             && state_ff != ST_ARMED),
    .div_i  (sar_clock_divider_ff),
    .tick_o (sar_tick)
  );

  sar_step #(
    .BITS (adc_ctrl_pkg::RES_BITS)
  ) u_sar (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .load_i  (state_ff != ST_CONVERT && nxt_state == ST_CONVERT),
    .step_i  (state_ff == ST_CONVERT && sar_tick
              && clk_cnt_ff >= 4'h1),
    .cmp_i   (cmp_sync_ff),
    .trial_o (sar_trial),
    .mask_o  (sar_mask)
  );

  // ----------------------------------------------------------------------
  // Synchronisers and sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      strobe_meta_ff <= 1'b0;
      strobe_sync_ff <= 1'b0;
      strobe_prev_ff <= 1'b0;
      cmp_meta_ff    <= 1'b0;
      cmp_sync_ff    <= 1'b0;
      state_ff       <= ST_IDLE;
      clk_cnt_ff     <= 4'h0;
    end else begin
      strobe_meta_ff <= external_convert_strobe_i;
      strobe_sync_ff <= strobe_meta_ff;
      strobe_prev_ff <= strobe_sync_ff;
      cmp_meta_ff    <= cmp_i;
      cmp_sync_ff    <= cmp_meta_ff;
      state_ff       <= nxt_state;
      clk_cnt_ff     <= nxt_clk_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Control register, flags and result
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      converter_power_enable_ff    <= 1'b0;
      low_power_track_select_ff    <= 1'b0;
      conversion_done_flag_ff      <= 1'b0;
      conversion_active_ff         <= 1'b0;
      conversion_trigger_select_ff <= 3'b000;
      sar_clock_divider_ff         <= adc_ctrl_pkg::DIV_RST;
      left_align_select_ff         <= 1'b0;
      neg_input_ff                 <= adc_ctrl_pkg::NEG_RST;
      standby_ff                   <= 1'b0;
      result_high_byte_ff          <= 8'h00;
      result_low_byte_ff           <= 8'h00;
    end else begin
      if (wr_acc && hit_ctrl) begin
        converter_power_enable_ff    <= pwdata[adc_ctrl_pkg::PWR_BIT];
        low_power_track_select_ff    <= pwdata[adc_ctrl_pkg::TRACK_BIT];
        conversion_trigger_select_ff <= pwdata[adc_ctrl_pkg::TRIG_LSB +: 3];
        // Software may clear done; a completing conversion wins
        conversion_done_flag_ff <= pwdata[adc_ctrl_pkg::DONE_BIT] || conv_end;
      end else if (conv_end) begin
        conversion_done_flag_ff <= 1'b1;
      end
      if (wr_acc && hit_cfg) begin
        sar_clock_divider_ff <= pwdata[adc_ctrl_pkg::DIV_LSB +: 5];
        left_align_select_ff <= pwdata[adc_ctrl_pkg::ALIGN_BIT];
      end
      if (wr_acc && hit_in) begin
        neg_input_ff <= pwdata[adc_ctrl_pkg::NEG_LSB +: 5];
        standby_ff   <= pwdata[adc_ctrl_pkg::STANDBY_BIT];
      end
      // Active high from start through the last SAR clock
      if (start) begin
        conversion_active_ff <= 1'b1;
      end else if (conv_end || !converter_power_enable_ff) begin
        conversion_active_ff <= 1'b0;
      end
      if (conv_end) begin
        result_high_byte_ff <= formatted[15:8];
        result_low_byte_ff  <= formatted[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB read and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = {converter_power_enable_ff, low_power_track_select_ff,
                     conversion_done_flag_ff, conversion_active_ff,
                     1'b0, conversion_trigger_select_ff};
    end else if (hit_cfg) begin
      rd_mux[7:0] = {sar_clock_divider_ff, left_align_select_ff, 2'b00};
    end else if (hit_res) begin
      rd_mux[15:0] = {result_high_byte_ff, result_low_byte_ff};
    end else if (hit_in) begin
      rd_mux[8:0] = {standby_ff, 3'b000, neg_input_ff};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      dac_code_o  <= 10'h000;
      track_o     <= 1'b0;
      analog_on_o <= 1'b0;
      done_irq_o  <= 1'b0;
    end else begin
      // One wait state: answer in the cycle after the access phase opens
      pready      <= psel && penable && !pready;
      pslverr     <= psel && penable && !pready && !mapped;
      prdata      <= (rd_acc && !pready) ? rd_mux : 32'h0000_0000;
      dac_code_o  <= sar_trial;
      analog_on_o <= converter_power_enable_ff;
      // Tracking: default mode off while converting; low-power mode
      // only in track or armed states; never in standby or powered down
      track_o <= converter_power_enable_ff && !standby_ff
                 && (low_power_track_select_ff
                     ? (nxt_state == ST_TRACK || nxt_state == ST_ARMED)
                     : (nxt_state != ST_CONVERT));
      done_irq_o <= conversion_done_flag_ff || conv_end;
    end
  end

endmodule : adc_conv_ctrl

/* src/adc_ctrl_pkg.sv */
/*
  Package for the converter control block: register offsets, field
  positions, reset values, trigger codes and sequencing counts.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFS = 8'h00;  // Control register
  localparam logic [7:0] CONFIG_OFFS  = 8'h04;  // Configuration register
  localparam logic [7:0] RESULT_OFFS  = 8'h08;  // High and low result bytes
  localparam logic [7:0] INPUT_OFFS   = 8'h0C;  // Negative input, standby

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int PWR_BIT    = 7;  // Power enable
  localparam int TRACK_BIT  = 6;  // Low-power track select
  localparam int DONE_BIT   = 5;  // Conversion done flag
  localparam int ACTIVE_BIT = 4;  // Conversion active
  localparam int TRIG_LSB   = 0;  // Trigger select, 3 bits

  // Configuration register fields
  localparam int DIV_LSB   = 3;  // Divider, 5 bits
  localparam int ALIGN_BIT = 2;  // Left-align select

  // Input register fields
  localparam int NEG_LSB     = 0;  // Negative input selection, 5 bits
  localparam int STANDBY_BIT = 8;  // Chip standby, tracking shut down

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] DIV_RST     = 5'h1F;  // Divider after reset
  localparam logic [4:0] NEG_GND     = 5'h1F;  // Negative input is ground
  localparam logic [4:0] NEG_RST     = 5'h1F;  // Reset: single-ended

  // ----------------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TRIG_SOFT   = 3'b000,
    TRIG_TMR0   = 3'b001,
    TRIG_TMR2   = 3'b010,
    TRIG_TMR1   = 3'b011,
    TRIG_STROBE = 3'b100,
    TRIG_TMR3   = 3'b101
  } trig_sel_t;

  // ----------------------------------------------------------------------
  // Sequencing counts, in SAR clocks, and result width
  // ----------------------------------------------------------------------
  localparam logic [3:0] TRACK_CLKS   = 4'h3;  // Low-power tracking period
  localparam logic [3:0] CONVERT_CLKS = 4'hE;  // Conversion length
  localparam int         RES_BITS     = 10;    // Result width

endpackage : adc_ctrl_pkg

/* src/sar_clk_div.sv */
/*
  SAR clock divider: emits a one-cycle enable every (div+1) clocks.
  Assumes a single clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sar_clk_div (
  input  wire logic       clk_i,     // System clock
  input  wire logic       nrst_i,    // Sync reset, active low
  input  wire logic       run_i,     // Divider runs while high
  input  wire logic [4:0] div_i,     // Divide value minus one
  output logic            tick_o     // One-cycle SAR clock enable
);

  logic [4:0] cnt_ff;   // Divider counter
  logic [4:0] nxt_cnt;  // Next counter value
  logic       wrap;     // Counter reached the divide value

  assign wrap    = (cnt_ff >= div_i);
  assign nxt_cnt = wrap ? 5'h00 : 5'(cnt_ff + 5'h01);

  // --------------------------------------------------------------------
  // Counter and tick
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt_ff <= 5'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_o <= wrap;
    end
  end

endmodule : sar_clk_div

/* src/sar_step.sv */
/*
  Successive-approximation register: resolves one bit per SAR tick,
  most significant first, against the comparator answer.
  Assumes the comparator settles within one SAR clock.
*/
`timescale 1ns/1ps
module sar_step #(
  parameter int BITS = 10  // Result width
) (
  input  wire logic            clk_i,    // System clock
  input  wire logic            nrst_i,   // Sync reset, active low
  input  wire logic            load_i,   // Start a new approximation
  input  wire logic            step_i,   // Resolve one bit
  input  wire logic            cmp_i,    // Comparator: input above trial
  output logic [BITS-1:0]      trial_o,  // Trial code to the DAC
  output logic [BITS-1:0]      mask_o    // Bit under test, one-hot
);

  // --------------------------------------------------------------------
  // Trial code and pointer
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      trial_o <= '0;
      mask_o  <= '0;
    end else if (load_i) begin
      trial_o <= {1'b1, {(BITS-1){1'b0}}};  // Start at mid-scale
      mask_o  <= {1'b1, {(BITS-1){1'b0}}};
    end else if (step_i && (mask_o != '0)) begin
      // Keep or drop tested bit, try next one down
      trial_o <= (cmp_i ? trial_o : (trial_o & ~mask_o)) | (mask_o >> 1);
      mask_o  <= mask_o >> 1;
    end
  end

endmodule : sar_step

/* tb/adc_conv_ctrl_tb.sv */
/*
  Testbench for the converter control: APB tasks and result checks.
  Assumes the far-side model for timers, strobe and comparator.
*/
`timescale 1ns/1ps
module adc_conv_ctrl_tb;
  // ----------------------------------------------------------------------
  // Signals, tables and tasks
  // ----------------------------------------------------------------------
  localparam logic [7:0] ctl = adc_ctrl_pkg::CONTROL_OFFS;  // Control
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  ovf;
  logic [9:0]  dac;
  logic stb, cmp, s2, s3, trk, aon, irq;
  int miscompares = 0, n_checks = 0, cnt;
  int good [1:5] = '{0, 2, 1, 6, 5};  // Selected source per code
  int bad [1:5] = '{1, 3, 0, 2, 4};   // Unselected source per code
  logic [9:0] tg [8] = '{10'h3FF, 10'h3FF, 10'h200, 10'h000,
                         10'h1FF, 10'h200, 10'h1FF, 10'h200};
  logic [15:0] ex [8] = '{16'h03FF, 16'hFFC0, 16'h8000, 16'h0000,
                          16'h01FF, 16'hFE00, 16'h7FC0, 16'h8000};
  logic [7:0] al = 8'b1100_0110;  // Left align per case
  adc_conv_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr0_ovf_i(ovf[0]), .tmr1_ovf_i(ovf[1]), .tmr2_lo_ovf_i(ovf[2]),
    .tmr2_hi_ovf_i(ovf[3]), .tmr2_split_i(s2), .tmr3_lo_ovf_i(ovf[4]),
    .tmr3_hi_ovf_i(ovf[5]), .tmr3_split_i(s3),
    .external_convert_strobe_i(stb), .cmp_i(cmp), .dac_code_o(dac),
    .track_o(trk), .analog_on_o(aon), .done_irq_o(irq));
  far_side_model far (.clk_i(clk_i), .dac_code_i(dac), .ovf_o(ovf),
    .stb_o(stb), .cmp_o(cmp), .split2_o(s2), .split3_o(s3));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Poll the done flag, not the active bit
  task automatic wait_done();
    repeat (100) begin
      apb(0, ctl, 0);
      if (rd[5] === 1'b1) break;
    end
  endtask : wait_done
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    #80_000;
    miscompares++;
    complete_run();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {nrst_i, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(0, ctl, 0);
    check(rd, 32'h0000_0000);
    apb(0, adc_ctrl_pkg::CONFIG_OFFS, 0);
    check(rd, 32'h0000_00F8);
    apb(0, adc_ctrl_pkg::INPUT_OFFS, 0);
    check(rd, 32'h0000_001F);
    apb(0, 8'h10, 0);
    check({rd[30:0], err}, 32'h0000_0001);
    check({aon, trk}, 2'b00);
    apb(1, ctl, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    check({aon, trk}, 2'b11);
    apb(1, adc_ctrl_pkg::INPUT_OFFS, 32'h0000_011F);
    repeat (2) @(posedge clk_i);
    check(trk, 1'b0);
    for (int i = 0; i < 8; i++) begin
      apb(1, adc_ctrl_pkg::CONFIG_OFFS, 32'h18 | (al[i] << 2));
      apb(1, adc_ctrl_pkg::INPUT_OFFS, (i < 4) ? 32'h1F : 32'h00);
      far.target = tg[i];
      apb(1, ctl, 32'h0000_0090);
      apb(0, ctl, 0);
      check(rd, 32'h0000_0090);
      for (cnt = 0; trk !== 1'b1 && cnt < 999; cnt++) begin
        @(posedge clk_i);
      end
      check(cnt inside {[44:58]}, 1'b1);
      wait_done();
      apb(0, adc_ctrl_pkg::RESULT_OFFS, 0);
      check(rd, ex[i]);
      check(irq, 1'b1);
    end
    apb(1, ctl, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    apb(1, ctl, 32'h0000_0010);
    repeat (80) @(posedge clk_i);
    apb(0, ctl, 0);
    check(rd, 32'h0000_0000);
    for (int c = 1; c < 6; c++) begin
      apb(1, ctl, 32'h80 | c | (c == 4) << 6);
      far.fire(bad[c]);
      repeat (80) @(posedge clk_i);
      apb(0, ctl, 0);
      check(rd, 32'h80 | c | (c == 4) << 6);
      check(trk, 1'b1);
      far.fire(good[c]);
      wait_done();
      check(rd, 32'hA0 | c | (c == 4) << 6);
    end
    apb(1, ctl, 32'h0000_00C0);
    apb(1, ctl, 32'h0000_00D0);
    cnt = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (trk === 1'b1) cnt++;
    end
    check(cnt inside {[9:14]}, 1'b1);
    wait_done();
    check(rd, 32'h0000_00E0);
    complete_run();
  end
endmodule : adc_conv_ctrl_tb

/* tb/adc_ctrl_props.sv */
/*
  Checker for the converter control block: APB answer and power rules.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module adc_ctrl_chk (
  input  wire logic        clk_i,        // System clock
  input  wire logic        nrst_i,       // Sync reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic [7:0]  paddr,        // APB address
  input  wire logic [31:0] prdata,       // APB read data
  input  wire logic        pready,       // APB ready
  input  wire logic        pslverr,      // APB error
  input  wire logic        analog_on_o,  // Analog powered
  input  wire logic        track_o       // Tracking
);
  // ----------------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire bad_addr = (paddr[7:4] != 4'h0) || (paddr[1:0] != 2'h0);  // Unmapped
  sequence acc_wait;  // Access phase, not yet answered
    psel && penable && !pready;
  endsequence
  sequence acc_done;  // Access phase answered
    psel && penable && pready;
  endsequence
  ready_wait_a: assert property (acc_wait |=> acc_done)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (acc_done and bad_addr |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_done and !bad_addr |-> !pslverr)
    else $error("mapped access refused");
  power_off_a: assert property (!analog_on_o |-> !track_o)
    else $error("tracking while powered down");
endmodule : adc_ctrl_chk

bind adc_conv_ctrl adc_ctrl_chk chk (.*);

/* tb/far_side_model.sv */
/*
  Far side: timer overflow pulses, strobe pin and comparator.
  Assumes the bench calls fire() and sets target.
*/
`timescale 1ns/1ps
module far_side_model (
  input  wire logic       clk_i,       // System clock
  input  wire logic [9:0] dac_code_i,  // Trial code
  output logic      [5:0] ovf_o,       // T3 hi/lo, T2 hi/lo, T1, T0
  output logic            stb_o,       // Strobe pin, dedicated
  output logic            cmp_o,       // Input above trial
  output logic            split2_o,    // Timer 2 in 8-bit mode
  output logic            split3_o     // Timer 3 in 8-bit mode, held low
);
  // ----------------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------------
  logic [9:0] target = 10'h000;  // Analog input as a code
  assign split2_o = 1'b1;
  assign split3_o = 1'b0;
  assign cmp_o = target >= dac_code_i;  // Comparator answer
  // Strobe pin kept off the crossbar, driven only here
  initial {ovf_o, stb_o} = 7'h00;
  // One-cycle overflow, or strobe high four cycles for index 6
  task automatic fire(input int k);
    @(posedge clk_i);
    ovf_o <= (k < 6) ? 6'h01 << k : 6'h00;
    stb_o <= (k == 6);
    @(posedge clk_i);
    ovf_o <= 6'h00;
    repeat (3) @(posedge clk_i);
    stb_o <= 1'b0;
  endtask : fire
endmodule : far_side_model
